// ### rtl/ild_pkg.sv
// package of constants and types for the input line interrupt dispatch
package ild_pkg;
    localparam int          NUM_LINES       = 16;
    localparam int          NUM_HS_LINES    = 6;
    localparam int          CLK_MHZ         = 25;
    localparam logic [7:0]  LINE_PRIO_BASE  = 8'h05;
    localparam logic [7:0]  TIMER_PRIO_BASE = 8'h01;
    localparam logic [7:0]  TIMER_VEC_BASE  = 8'h1C;
    localparam logic [15:0] PARAM_ERR_CODE  = 16'h0BB8;
    localparam logic [7:0]  VEC_RESET       = 8'h00;
    // filter times in microseconds, high-speed lines then standard lines
    localparam int HS_US [6] = '{10, 100, 200, 400, 600, 1000};
    localparam int ST_US [6] = '{100, 1000, 5000, 10000, 20000, 70000};
    localparam int FILT_W = 21;
    typedef enum logic [1:0] {ILD_TRIG_RISE, ILD_TRIG_FALL, ILD_TRIG_BOTH, ILD_TRIG_NONE} ild_trig_t;
    typedef enum logic [1:0] {ILD_FN_GENERAL, ILD_FN_INTERRUPT, ILD_FN_OTHER, ILD_FN_RSVD} ild_fn_t;
endpackage : ild_pkg

// ### rtl/ild_line.sv
// one input line: synchroniser, response-time filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module ild_line #(
    parameter bit HIGH_SPEED = 1'b0
) (
    input  wire logic       MCLK,
    input  wire logic       RSTN,
    input  wire logic       pin,
    input  wire logic [2:0] resp_sel,
    input  wire logic [1:0] trig,
    output logic            level,
    output logic            evt
);
    logic               s1_r, s2_r, lvl_r, lvl_nxt;
    logic [ild_pkg::FILT_W-1:0] cnt_r, cnt_nxt, lim;
    logic               evt_nxt;
    logic [2:0]         sel;

    always_comb begin
        sel = (resp_sel > 3'h5) ? 3'h5 : resp_sel;
        lim = HIGH_SPEED ? ild_pkg::FILT_W'(ild_pkg::HS_US[sel] * ild_pkg::CLK_MHZ)
                         : ild_pkg::FILT_W'(ild_pkg::ST_US[sel] * ild_pkg::CLK_MHZ);
        lvl_nxt = lvl_r;
        cnt_nxt = '0;
        if (s2_r != lvl_r) begin
            cnt_nxt = cnt_r + 1'b1;
            if (cnt_nxt >= lim) begin
                lvl_nxt = s2_r;
                cnt_nxt = '0;
            end
        end
        evt_nxt = 1'b0;
        if (lvl_nxt != lvl_r) begin
            case (trig)
                ild_pkg::ILD_TRIG_RISE: evt_nxt = lvl_nxt;
                ild_pkg::ILD_TRIG_FALL: evt_nxt = !lvl_nxt;
                ild_pkg::ILD_TRIG_BOTH: evt_nxt = 1'b1;
                default:                evt_nxt = 1'b0;
            endcase
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            s1_r  <= 1'b0;
            s2_r  <= 1'b0;
            lvl_r <= 1'b0;
            cnt_r <= '0;
            evt   <= 1'b0;
        end else begin
            s1_r  <= pin;
            s2_r  <= s1_r;
            lvl_r <= lvl_nxt;
            cnt_r <= cnt_nxt;
            evt   <= evt_nxt;
        end
    end
    assign level = lvl_r;
endmodule : ild_line
`default_nettype wire

// ### rtl/ild_top.sv
// input line interrupt dispatch: latch, mask, priority and vector relocation
//
// Contract
// - triggered interrupt line requests its routine
// - per-line function, filter time, trigger held
// - line n defaults to vector n
// - line priorities 5..20 ascending by line
// - priorities 1..4 reserved for timer vectors 28..31
// - vector numbers relocatable by configuration
// - relocation: start vector, count, input, index
// - non-interrupt line in range: error 3000
// - trigger rising, falling or both edges
// - both-edge: later edges dropped while serving
// - global enable, disable, per-routine mask
// - filter times per high-speed or standard line
`timescale 1ns/1ps
`default_nettype none
module ild_top (
    input  wire logic        MCLK,
    input  wire logic        RSTN,
    input  wire logic [15:0] EXTERNAL_INPUT_LINES,
    input  wire logic [31:0] LINE_FUNC_SEL,
    input  wire logic [47:0] LINE_RESP_SEL,
    input  wire logic [31:0] LINE_TRIG_SEL,
    input  wire logic        RELOC_EN,
    input  wire logic [7:0]  RELOC_START_VEC,
    input  wire logic [4:0]  RELOC_COUNT,
    input  wire logic [3:0]  RELOC_START_INPUT,
    input  wire logic [3:0]  RELOC_START_INDEX,
    input  wire logic        GLOBAL_ENABLE_INSTR,
    input  wire logic        GLOBAL_DISABLE_INSTR,
    input  wire logic        MASK_INSTR,
    input  wire logic [15:0] MASK_VALUE,
    input  wire logic [3:0]  TIMER_REQ,
    input  wire logic        ROUTINE_DONE,
    output logic             IRQ_REQ,
    output logic [7:0]       IRQ_VECTOR,
    output logic [7:0]       IRQ_PRIORITY,
    output logic             IN_SERVICE,
    output logic [15:0]      PENDING,
    output logic [15:0]      LINE_LEVEL,
    output logic             PARAM_ERR,
    output logic [15:0]      PARAM_ERR_CODE_OUT
);
    localparam int N = ild_pkg::NUM_LINES;

    logic [N-1:0] evt, lvl, is_int;
    logic [N-1:0] pend_r, pend_nxt, mask_r, mask_nxt, inrng;
    logic         gen_r, gen_nxt, busy_r, busy_nxt, req_nxt, err_nxt;
    logic [7:0]   vec_nxt, pri_nxt;
    logic [4:0]   sel_idx;
    logic [3:0]   tsync1_r, tsync2_r;
    logic [4:0]   srv_r, srv_nxt;
    logic [4:0]   win;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_line
            ild_line #(.HIGH_SPEED(g < ild_pkg::NUM_HS_LINES)) u_line (
                .MCLK     (MCLK),
                .RSTN     (RSTN),
                .pin      (EXTERNAL_INPUT_LINES[g]),
                .resp_sel (LINE_RESP_SEL[3*g +: 3]),
                .trig     (LINE_TRIG_SEL[2*g +: 2]),
                .level    (lvl[g]),
                .evt      (evt[g])
            );
            assign is_int[g] = (LINE_FUNC_SEL[2*g +: 2] == ild_pkg::ILD_FN_INTERRUPT);
        end
    endgenerate

    // vector of a line: default n, or relocated inside the configured range
    function automatic logic [7:0] line_vec(input logic [4:0] n);
        logic [4:0] off;
        off = n - {1'b0, RELOC_START_INPUT};
        if (RELOC_EN && n >= {1'b0, RELOC_START_INPUT} && off < RELOC_COUNT)
            return RELOC_START_VEC + 8'(off) + 8'(RELOC_START_INDEX);
        return 8'(n);
    endfunction : line_vec

    always_comb begin
        for (int i = 0; i < N; i++)
            inrng[i] = RELOC_EN && (5'(i) >= {1'b0, RELOC_START_INPUT})
                       && (5'(i) - {1'b0, RELOC_START_INPUT} < RELOC_COUNT);
        err_nxt = |(inrng & ~is_int);

        gen_nxt  = GLOBAL_ENABLE_INSTR ? 1'b1 : (GLOBAL_DISABLE_INSTR ? 1'b0 : gen_r);
        mask_nxt = MASK_INSTR ? MASK_VALUE : mask_r;

        // set wins over the service clear; a latched cause absorbs later edges
        pend_nxt = pend_r;
        busy_nxt = busy_r;
        srv_nxt  = srv_r;
        if (busy_r && ROUTINE_DONE)
            busy_nxt = 1'b0;
        for (int i = 0; i < N; i++) begin
            if (evt[i] && is_int[i] && !(busy_r && srv_r == 5'(i)))
                pend_nxt[i] = 1'b1;
        end

        // timers (priority 1..4) beat lines; lowest index = smallest level
        win     = 5'h1F;
        sel_idx = 5'h1F;
        for (int i = N-1; i >= 0; i--)
            if (pend_r[i] && !mask_r[i])
                win = 5'(i);
        for (int t = 3; t >= 0; t--)
            if (tsync2_r[t])
                sel_idx = 5'(16 + t);
        if (sel_idx == 5'h1F)
            sel_idx = win;

        req_nxt = 1'b0;
        vec_nxt = IRQ_VECTOR;
        pri_nxt = IRQ_PRIORITY;
        if (gen_r && !busy_r && sel_idx != 5'h1F) begin
            req_nxt  = 1'b1;
            busy_nxt = 1'b1;
            srv_nxt  = sel_idx;
            if (sel_idx >= 5'h10) begin
                vec_nxt = ild_pkg::TIMER_VEC_BASE + 8'(sel_idx - 5'h10);
                pri_nxt = ild_pkg::TIMER_PRIO_BASE + 8'(sel_idx - 5'h10);
            end else begin
                vec_nxt = line_vec(sel_idx);
                pri_nxt = ild_pkg::LINE_PRIO_BASE + 8'(sel_idx);
                pend_nxt[sel_idx[3:0]] = evt[sel_idx[3:0]] ? pend_r[sel_idx[3:0]] : 1'b0;
            end
        end
    end

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            tsync1_r           <= '0;
            tsync2_r           <= '0;
            pend_r             <= '0;
            mask_r             <= '0;
            gen_r              <= 1'b0;
            busy_r             <= 1'b0;
            srv_r              <= 5'h1F;
            IRQ_REQ            <= 1'b0;
            IRQ_VECTOR         <= ild_pkg::VEC_RESET;
            IRQ_PRIORITY       <= 8'h00;
            IN_SERVICE         <= 1'b0;
            PENDING            <= '0;
            LINE_LEVEL         <= '0;
            PARAM_ERR          <= 1'b0;
            PARAM_ERR_CODE_OUT <= 16'h0000;
        end else begin
            tsync1_r           <= TIMER_REQ;
            tsync2_r           <= tsync1_r;
            pend_r             <= pend_nxt;
            mask_r             <= mask_nxt;
            gen_r              <= gen_nxt;
            busy_r             <= busy_nxt;
            srv_r              <= srv_nxt;
            IRQ_REQ            <= req_nxt;
            IRQ_VECTOR         <= vec_nxt;
            IRQ_PRIORITY       <= pri_nxt;
            IN_SERVICE         <= busy_nxt;
            PENDING            <= pend_nxt;
            LINE_LEVEL         <= lvl;
            PARAM_ERR          <= err_nxt;
            PARAM_ERR_CODE_OUT <= err_nxt ? ild_pkg::PARAM_ERR_CODE : 16'h0000;
        end
    end

    property p_req_needs_enable;
        @(posedge MCLK) disable iff (!RSTN) $rose(IRQ_REQ) |-> $past(gen_r);
    endproperty
    a_req_needs_enable: assert property (p_req_needs_enable) else $error("request while disabled");

    property p_req_one_cycle;
        @(posedge MCLK) disable iff (!RSTN) IRQ_REQ |=> !IRQ_REQ;
    endproperty
    a_req_one_cycle: assert property (p_req_one_cycle) else $error("request longer than a cycle");

    property p_line_prio;
        @(posedge MCLK) disable iff (!RSTN)
            IRQ_REQ && IRQ_PRIORITY >= 8'h05 |-> IRQ_PRIORITY <= 8'h14;
    endproperty
    a_line_prio: assert property (p_line_prio) else $error("line priority out of 5..20");

    property p_timer_vec;
        @(posedge MCLK) disable iff (!RSTN)
            IRQ_REQ && IRQ_PRIORITY < 8'h05 |-> IRQ_VECTOR == IRQ_PRIORITY + 8'h1B;
    endproperty
    a_timer_vec: assert property (p_timer_vec) else $error("timer vector not 28..31");

    property p_default_vec;
        @(posedge MCLK) disable iff (!RSTN)
            IRQ_REQ && !$past(RELOC_EN) && IRQ_PRIORITY >= 8'h05 |-> IRQ_VECTOR == IRQ_PRIORITY - 8'h05;
    endproperty
    a_default_vec: assert property (p_default_vec) else $error("default vector mismatch");

    property p_err_code;
        @(posedge MCLK) disable iff (!RSTN) PARAM_ERR |-> PARAM_ERR_CODE_OUT == 16'h0BB8;
    endproperty
    a_err_code: assert property (p_err_code) else $error("error code not 3000");

    property p_busy_blocks;
        @(posedge MCLK) disable iff (!RSTN) IN_SERVICE && !ROUTINE_DONE |=> !IRQ_REQ;
    endproperty
    a_busy_blocks: assert property (p_busy_blocks) else $error("request during service");

    property p_masked_pend;
        @(posedge MCLK) disable iff (!RSTN)
            IRQ_REQ && IRQ_PRIORITY >= 8'h05
            |-> (($past(mask_r) >> (IRQ_PRIORITY[3:0] - 4'h5)) & 16'h0001) == 16'h0000;
    endproperty
    a_masked_pend: assert property (p_masked_pend) else $error("masked line served");

    property p_err_clear;
        @(posedge MCLK) disable iff (!RSTN) !PARAM_ERR |-> PARAM_ERR_CODE_OUT == 16'h0000;
    endproperty
    a_err_clear: assert property (p_err_clear) else $error("error code without error");

    property p_req_in_service;
        @(posedge MCLK) disable iff (!RSTN) IRQ_REQ |-> IN_SERVICE;
    endproperty
    a_req_in_service: assert property (p_req_in_service) else $error("request not in service");

    c_line_irq:  cover property (@(posedge MCLK) disable iff (!RSTN) IRQ_REQ && IRQ_PRIORITY >= 8'h05);
    c_timer_irq: cover property (@(posedge MCLK) disable iff (!RSTN) IRQ_REQ && IRQ_PRIORITY < 8'h05);
    c_reloc_irq: cover property (@(posedge MCLK) disable iff (!RSTN) IRQ_REQ && IRQ_VECTOR >= 8'h32);
    c_param_err: cover property (@(posedge MCLK) disable iff (!RSTN) PARAM_ERR);
endmodule : ild_top
`default_nettype wire

// ### testbench/ild_field_dev.sv
// field device model that drives the sixteen input lines
`timescale 1ns/1ps
`default_nettype none
module ild_field_dev (
    input  wire logic        MCLK,
    input  wire logic [3:0]  SEL,
    input  wire logic        LVL,
    input  wire logic        STB,
    output logic [15:0]      LINES
);
    initial LINES = 16'h0000;
    // a field contact holds its level until it is switched again
    // strobe taken on the rising edge so it never races the falling-edge drive
    always @(posedge MCLK) if (STB) LINES[SEL] <= LVL;
endmodule : ild_field_dev
`default_nettype wire

// ### testbench/ild_top_test.sv
// self-checking bench for the input line interrupt dispatch
`timescale 1ns/1ps
`default_nettype none
module ild_top_test;
    logic        mclk = 0, rstn = 0, gen = 0, gdis = 0, mski = 0, reloc_en = 0, done = 0, stb = 0, lvl = 0;
    logic [3:0]  sel = 0, tmr = 0, rsi = 0, rsx = 0;
    logic [15:0] lines, mval = 0, pend, lvlo, ecode;
    logic [31:0] fsel = 32'h55555555, tsel = 0;
    logic [47:0] rsel = 0;
    logic [7:0]  rsv = 0, vec, pri;
    logic [4:0]  rcnt = 0;
    logic        irq, insv, perr;
    int          errors = 0, check_count = 0, cyc = 0;

    ild_field_dev fld (.MCLK(mclk), .SEL(sel), .LVL(lvl), .STB(stb), .LINES(lines));
    ild_top dut (.MCLK(mclk), .RSTN(rstn), .EXTERNAL_INPUT_LINES(lines), .LINE_FUNC_SEL(fsel),
        .LINE_RESP_SEL(rsel), .LINE_TRIG_SEL(tsel), .RELOC_EN(reloc_en), .RELOC_START_VEC(rsv),
        .RELOC_COUNT(rcnt), .RELOC_START_INPUT(rsi), .RELOC_START_INDEX(rsx),
        .GLOBAL_ENABLE_INSTR(gen), .GLOBAL_DISABLE_INSTR(gdis), .MASK_INSTR(mski), .MASK_VALUE(mval),
        .TIMER_REQ(tmr), .ROUTINE_DONE(done), .IRQ_REQ(irq), .IRQ_VECTOR(vec), .IRQ_PRIORITY(pri),
        .IN_SERVICE(insv), .PENDING(pend), .LINE_LEVEL(lvlo), .PARAM_ERR(perr), .PARAM_ERR_CODE_OUT(ecode));

    always #20 mclk = ~mclk;

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            errors++;
            print_verdict();
        end
    end

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic pin(input logic [3:0] ln, input logic lv);
        @(negedge mclk);
        sel = ln;
        lvl = lv;
        stb = 1;
        @(negedge mclk);
        stb = 0;
    endtask : pin

    task automatic wait_irq(input logic [7:0] ev, input logic [7:0] ep);
        int n;
        n = 0;
        while (irq !== 1'b1 && n < 4000) begin
            @(negedge mclk);
            n++;
        end
        chk("irq", 16'h0001, {15'h0000, irq});
        chk("in service", 16'h0001, {15'h0000, insv});
        chk("vector", {8'h00, ev}, {8'h00, vec});
        chk("priority", {8'h00, ep}, {8'h00, pri});
    endtask : wait_irq

    task automatic no_irq(input int n);
        logic seen;
        seen = 0;
        repeat (n) begin
            @(negedge mclk);
            if (irq !== 1'b0) seen = 1;
        end
        chk("no irq", 16'h0000, {15'h0000, seen});
    endtask : no_irq

    // finish the running routine; timers are dropped first so they do not retrigger
    task automatic fin;
        tmr = 4'h0;
        repeat (4) @(negedge mclk);
        done = 1;
        @(negedge mclk);
        done = 0;
        chk("service end", 16'h0000, {15'h0000, insv});
    endtask : fin

    task automatic pulse_en(input logic en, input logic dis, input logic mk);
        @(negedge mclk);
        {gen, gdis, mski} = {en, dis, mk};
        @(negedge mclk);
        {gen, gdis, mski} = 3'h0;
    endtask : pulse_en

    task automatic t_default;
        pin(4'h0, 1);
        wait_irq(8'h00, 8'h05);
        fin();
        chk("level", 16'h0001, {15'h0000, lvlo[0]});
        pin(4'hF, 1);
        wait_irq(8'h0F, 8'h14);
        fin();
        $display("test default done");
    endtask : t_default

    task automatic t_fall;
        tsel[3:2] = 2'h1;
        pin(4'h1, 1);
        no_irq(400);
        pin(4'h1, 0);
        wait_irq(8'h01, 8'h06);
        fin();
        tsel[3:2] = 2'h3;
        pin(4'h1, 1);
        no_irq(400);
        pin(4'h1, 0);
        no_irq(400);
        $display("test fall done");
    endtask : t_fall

    task automatic t_prio;
        pulse_en(0, 1, 0);
        pin(4'h3, 1);
        pin(4'h2, 1);
        tmr = 4'h1;
        no_irq(400);
        pulse_en(1, 0, 0);
        wait_irq(8'h1C, 8'h01);
        fin();
        wait_irq(8'h02, 8'h07);
        fin();
        wait_irq(8'h03, 8'h08);
        fin();
        $display("test priority done");
    endtask : t_prio

    task automatic t_mask;
        mval = 16'h0010;
        pulse_en(0, 0, 1);
        pin(4'h4, 1);
        no_irq(400);
        chk("masked pending", 16'h0001, {15'h0000, pend[4]});
        mval = 16'h0000;
        pulse_en(0, 0, 1);
        wait_irq(8'h04, 8'h09);
        fin();
        $display("test mask done");
    endtask : t_mask

    task automatic t_reloc;
        {reloc_en, rsv, rcnt, rsi, rsx} = {1'b1, 8'h32, 5'h02, 4'h0, 4'h0};
        tsel[3:2] = 2'h0;
        no_irq(4);
        chk("param err", 16'h0000, {15'h0000, perr});
        chk("err code", 16'h0000, ecode);
        pin(4'h1, 1);
        wait_irq(8'h33, 8'h06);
        fin();
        fsel[3:0] = 4'h0;
        no_irq(4);
        chk("param err", 16'h0001, {15'h0000, perr});
        chk("err code", 16'h0BB8, ecode);
        fsel[3:0] = 4'h5;
        reloc_en = 0;
        $display("test relocation done");
    endtask : t_reloc

    task automatic t_both;
        tsel[5:4] = 2'h2;
        pin(4'h2, 0);
        wait_irq(8'h02, 8'h07);
        pin(4'h2, 1);
        no_irq(400);
        fin();
        no_irq(400);
        chk("pending", 16'h0000, {15'h0000, pend[2]});
        $display("test both edges done");
    endtask : t_both

    initial begin
        repeat (3) @(negedge mclk);
        rstn = 1;
        pulse_en(1, 0, 0);
        t_default();
        t_fall();
        t_prio();
        t_mask();
        t_reloc();
        t_both();
        print_verdict();
    end
endmodule : ild_top_test
`default_nettype wire
